// file: hdl/adcsq_control.sv
// global control, calibration timing and input routing of the converter
`timescale 1ns/1ps
`include "adcsq_defines.svh"
module adcsq_control #(
   parameter int CAL_CYCLES = `ADCSQ_CAL_CYCLES,
   parameter bit FOUR_CHAN = 1'b0
) (
   // clock and reset
   input wire logic mclk,
   input wire logic reset,
   // register port
   input wire logic reg_wr,
   input wire logic [15:0] reg_wdata,
   input wire logic status_rd,
   output logic [15:0] global_control,
   output logic [15:0] status,
   // sequencer handshake
   input wire logic instr_done,
   input wire adcsq_pkg::adcsq_sel_t instr_sel,
   output logic seq_running,
   output logic [2:0] instr_ptr,
   output logic fifo_clear,
   output logic clock_gate,
   // calibration engine
   output logic az_active,
   output logic cal_active,
   // multiplexer routing
   output adcsq_pkg::adcsq_route_t route
);
   // ==================================================
   // power-on reset and reset command
   logic [2:0] por_cnt = 3'h0;
   logic [1:0] rst_cnt;
   logic sys_rst;
   logic stby;
   logic run_req;
   logic az_req;
   logic cal_req;
   logic az_flag;
   logic cal_flag;
   logic [12:0] cnt;
   adcsq_pkg::adcsq_state_t state;
   logic az_done;
   logic cal_done;
   logic boundary;
   logic wr_reset;
   assign wr_reset = reg_wr && reg_wdata[`ADCSQ_BIT_RESET];
   // por counter preloaded, so power-up alone forces the reset command
   always_ff @(posedge mclk) begin
      if (por_cnt != 3'(`ADCSQ_POR_CYCLES)) begin
         por_cnt <= por_cnt + 3'h1;
      end
   end
   always_ff @(posedge mclk) begin
      if (reset || por_cnt != 3'(`ADCSQ_POR_CYCLES)) begin
         rst_cnt <= 2'(`ADCSQ_RESET_CYCLES);
      // entering standby forces the reset bit high; leaving it retriggers the command
      end else if (wr_reset || (reg_wr && (stby || reg_wdata[`ADCSQ_BIT_STBY]))) begin
         rst_cnt <= 2'(`ADCSQ_RESET_CYCLES);
      end else if (rst_cnt != 2'h0 && !stby) begin
         rst_cnt <= rst_cnt - 2'h1;
      end
   end
   assign sys_rst = (rst_cnt != 2'h0);
   // ==================================================
   // control bits
   always_ff @(posedge mclk) begin
      if (reset) begin
         stby <= 1'b0;
      end else if (reg_wr) begin
         stby <= reg_wdata[`ADCSQ_BIT_STBY];
      end
   end
   always_ff @(posedge mclk) begin
      if (reset) begin
         clock_gate <= 1'b0;
      end else begin
         clock_gate <= reg_wr ? reg_wdata[`ADCSQ_BIT_STBY] : stby;
      end
   end
   always_ff @(posedge mclk) begin
      if (reset || sys_rst) begin
         run_req <= 1'b0;
      end else if (reg_wr) begin
         run_req <= reg_wdata[`ADCSQ_BIT_RUN];
      end
   end
   // requests latch until the engine finishes them
   always_ff @(posedge mclk) begin
      if (reset || sys_rst) begin
         az_req <= 1'b0;
      end else if (reg_wr && reg_wdata[`ADCSQ_BIT_AZ]) begin
         az_req <= 1'b1;
      end else if (az_done) begin
         az_req <= 1'b0;
      end
   end
   always_ff @(posedge mclk) begin
      if (reset || sys_rst) begin
         cal_req <= 1'b0;
      end else if (reg_wr && reg_wdata[`ADCSQ_BIT_CAL]) begin
         cal_req <= 1'b1;
      end else if (cal_done) begin
         cal_req <= 1'b0;
      end
   end
   // ==================================================
   // sequencer and calibration timing
   assign boundary = (state == adcsq_pkg::ADCSQ_IDLE) ||
                     (state == adcsq_pkg::ADCSQ_RUN && instr_done);
   assign az_done = (state == adcsq_pkg::ADCSQ_AZ) && cnt == 13'h0001;
   assign cal_done = (state == adcsq_pkg::ADCSQ_CAL) && cnt == 13'h0001;
   always_ff @(posedge mclk) begin
      if (reset || sys_rst || stby) begin
         state <= adcsq_pkg::ADCSQ_IDLE;
         cnt <= 13'h0000;
      end else begin
         unique case (state)
            adcsq_pkg::ADCSQ_IDLE, adcsq_pkg::ADCSQ_RUN: begin
               if (boundary && cal_req) begin
                  state <= adcsq_pkg::ADCSQ_CAL;
                  cnt <= 13'(CAL_CYCLES);
               end else if (boundary && az_req) begin
                  state <= adcsq_pkg::ADCSQ_AZ;
                  cnt <= 13'(`ADCSQ_AZ_CYCLES);
               end else if (boundary) begin
                  state <= run_req ? adcsq_pkg::ADCSQ_RUN : adcsq_pkg::ADCSQ_IDLE;
               end
            end
            adcsq_pkg::ADCSQ_AZ, adcsq_pkg::ADCSQ_CAL: begin
               cnt <= cnt - 13'h0001;
               if (cnt == 13'h0001) begin
                  state <= run_req ? adcsq_pkg::ADCSQ_RUN : adcsq_pkg::ADCSQ_IDLE;
               end
            end
         endcase
      end
   end
   always_ff @(posedge mclk) begin
      if (reset || sys_rst) begin
         instr_ptr <= 3'h0;
      end else if (state == adcsq_pkg::ADCSQ_RUN && instr_done) begin
         instr_ptr <= instr_ptr + 3'h1;
      end
   end
   // ==================================================
   // completion flags; set wins over the clearing read
   always_ff @(posedge mclk) begin
      if (reset || sys_rst) begin
         az_flag <= 1'b0;
         cal_flag <= 1'b0;
      end else begin
         az_flag <= az_done || (az_flag && !status_rd);
         cal_flag <= cal_done || (cal_flag && !status_rd);
      end
   end
   // ==================================================
   // registered outputs
   always_ff @(posedge mclk) begin
      if (reset) begin
         global_control <= `ADCSQ_CTRL_RESET;
         status <= 16'h0000;
         seq_running <= 1'b0;
         fifo_clear <= 1'b1;
         az_active <= 1'b0;
         cal_active <= 1'b0;
      end else begin
         global_control <= (reg_wr ? (reg_wdata & `ADCSQ_CTRL_WMASK) :
                            (global_control & `ADCSQ_CTRL_WMASK)) & 16'hfffe;
         global_control[`ADCSQ_BIT_RUN] <= (state == adcsq_pkg::ADCSQ_RUN);
         global_control[`ADCSQ_BIT_RESET] <= sys_rst;
         global_control[`ADCSQ_BIT_AZ] <= az_req && !az_done;
         global_control[`ADCSQ_BIT_CAL] <= cal_req && !cal_done;
         status <= 16'h0000;
         status[`ADCSQ_STAT_AZ_DONE] <= az_flag;
         status[`ADCSQ_STAT_CAL_DONE] <= cal_flag;
         status[`ADCSQ_STAT_PTR_LSB +: 3] <= instr_ptr;
         seq_running <= (state == adcsq_pkg::ADCSQ_RUN);
         fifo_clear <= sys_rst;
         az_active <= (state == adcsq_pkg::ADCSQ_AZ);
         cal_active <= (state == adcsq_pkg::ADCSQ_CAL);
      end
   end
   // ==================================================
   // input multiplexer decode
   adcsq_pkg::adcsq_route_t next_route;
   logic diag;
   assign diag = global_control[`ADCSQ_BIT_DIAG] && !FOUR_CHAN;
   always_comb begin
      next_route = '0;
      if (FOUR_CHAN) begin
         if (!instr_sel.pos_sel[2]) begin
            next_route.pos_en[instr_sel.pos_sel] = 1'b1;
         end
         if (instr_sel.neg_sel == 3'h0) begin
            next_route.neg_gnd = 1'b1;
         end else if (!instr_sel.neg_sel[2]) begin
            next_route.neg_en[instr_sel.neg_sel] = 1'b1;
         end
      end else if (diag) begin
         if (instr_sel.pos_sel == 3'h1) begin
            next_route.pos_vref = 1'b1;
         end else if (instr_sel.pos_sel != 3'h0) begin
            next_route.pos_en[instr_sel.pos_sel] = 1'b1;
         end
         if (instr_sel.neg_sel == 3'h1) begin
            next_route.neg_vref = 1'b1;
         end else if (instr_sel.neg_sel != 3'h0) begin
            next_route.neg_en[instr_sel.neg_sel] = 1'b1;
         end
      end else begin
         next_route.pos_en[instr_sel.pos_sel] = 1'b1;
         if (instr_sel.neg_sel == 3'h0) begin
            next_route.neg_gnd = 1'b1;
         end else begin
            next_route.neg_en[instr_sel.neg_sel] = 1'b1;
         end
      end
   end
   always_ff @(posedge mclk) begin
      if (reset) begin
         route <= '0;
      end else begin
         route <= next_route;
      end
   end
   // ==================================================
   // checks
   a_az_length: assert property (@(posedge mclk) disable iff (reset || sys_rst)
      $rose(state == adcsq_pkg::ADCSQ_AZ) |-> (state == adcsq_pkg::ADCSQ_AZ) [*8])
      else $error("offset correction ended early");
   a_az_flag_set: assert property (@(posedge mclk) disable iff (reset || sys_rst)
      az_done |=> az_flag)
      else $error("offset done flag not set");
   a_cal_flag_set: assert property (@(posedge mclk) disable iff (reset || sys_rst)
      cal_done |=> cal_flag ##1 status[`ADCSQ_STAT_CAL_DONE])
      else $error("calibration done flag not shown");
   a_az_at_once: assert property (@(posedge mclk) disable iff (reset || sys_rst || stby)
      (state == adcsq_pkg::ADCSQ_IDLE && az_req && !cal_req) |=>
      state == adcsq_pkg::ADCSQ_AZ)
      else $error("idle offset correction did not start");
   a_cal_waits: assert property (@(posedge mclk) disable iff (reset || sys_rst || stby)
      (state == adcsq_pkg::ADCSQ_RUN && !instr_done) |=>
      state != adcsq_pkg::ADCSQ_CAL)
      else $error("calibration broke into an instruction");
   a_reset_clear: assert property (@(posedge mclk) disable iff (reset)
      (wr_reset && !stby && !reg_wdata[`ADCSQ_BIT_STBY]) |=> sys_rst ##2 !sys_rst)
      else $error("reset bit did not self clear in two cycles");
   a_reset_effect: assert property (@(posedge mclk) disable iff (reset)
      sys_rst |=> instr_ptr == 3'h0 && fifo_clear && !az_flag && !cal_flag)
      else $error("reset command effects missing");
   a_ptr_shown: assert property (@(posedge mclk) disable iff (reset)
      status[`ADCSQ_STAT_PTR_LSB +: 3] == $past(instr_ptr))
      else $error("pointer not shown in status");
   a_run_read: assert property (@(posedge mclk) disable iff (reset)
      global_control[`ADCSQ_BIT_RUN] == $past(state == adcsq_pkg::ADCSQ_RUN))
      else $error("run bit does not show sequencer state");
   // ==================================================
   // sequencing and calibration checks
   // calibration counts of at least eight, such as the bench's 20, last the eight cycles checked
   a_cal_length: assert property (@(posedge mclk) disable iff (reset || sys_rst)
      $rose(state == adcsq_pkg::ADCSQ_CAL) |->
      (state == adcsq_pkg::ADCSQ_CAL) [*8])
      else $error("calibration ended early");
   a_az_waits: assert property (@(posedge mclk) disable iff (reset || sys_rst || stby)
      (state == adcsq_pkg::ADCSQ_RUN && !instr_done) |=>
      state != adcsq_pkg::ADCSQ_AZ)
      else $error("offset correction broke into an instruction");
   a_cal_at_once: assert property (@(posedge mclk) disable iff (reset || sys_rst || stby)
      (state == adcsq_pkg::ADCSQ_IDLE && cal_req) |=>
      state == adcsq_pkg::ADCSQ_CAL)
      else $error("idle calibration did not start");
   a_az_req_held: assert property (@(posedge mclk) disable iff (reset || sys_rst)
      (az_req && !az_done) |=>
      az_req)
      else $error("pending offset correction lost");
   a_cal_req_held: assert property (@(posedge mclk) disable iff (reset || sys_rst)
      (cal_req && !cal_done) |=>
      cal_req)
      else $error("pending calibration lost");
   a_run_holds: assert property (@(posedge mclk) disable iff (reset || sys_rst || stby)
      (state == adcsq_pkg::ADCSQ_RUN && !instr_done) |=>
      state == adcsq_pkg::ADCSQ_RUN)
      else $error("sequencer left an instruction unfinished");
   a_cal_resume: assert property (@(posedge mclk) disable iff (reset || sys_rst || stby)
      (state == adcsq_pkg::ADCSQ_CAL && cnt == 13'h0001 && run_req) |=>
      state == adcsq_pkg::ADCSQ_RUN)
      else $error("sequencer did not resume after calibration");
   a_az_bit_clear: assert property (@(posedge mclk) disable iff (reset)
      az_done |=>
      !global_control[`ADCSQ_BIT_AZ])
      else $error("offset correction bit not cleared");
   a_standby_hold: assert property (@(posedge mclk) disable iff (reset)
      stby |->
      sys_rst)
      else $error("reset bit released during standby");
   // ==================================================
   // routing checks
   a_four_none: assert property (@(posedge mclk) disable iff (reset)
      (FOUR_CHAN && instr_sel.pos_sel[2]) |=>
      route.pos_en == 8'h00)
      else $error("four-channel high code routed an input");
   a_neg_ground: assert property (@(posedge mclk) disable iff (reset)
      (FOUR_CHAN && instr_sel.neg_sel == 3'h0) |=>
      route.neg_gnd)
      else $error("negative output not grounded");
   a_diag_vref: assert property (@(posedge mclk) disable iff (reset)
      (diag && instr_sel.pos_sel == 3'h1) |=>
      route.pos_vref)
      else $error("diagnostic reference not connected");
   c_az_run: cover property (@(posedge mclk) az_done && run_req);
   c_az_idle: cover property (@(posedge mclk) az_done && !run_req);
   c_standby: cover property (@(posedge mclk) $rose(stby));
   c_cal_done: cover property (@(posedge mclk) cal_done);
   c_run_stop: cover property (@(posedge mclk) $fell(state == adcsq_pkg::ADCSQ_RUN));
endmodule

// file: pkg/adcsq_defines.svh
// constants of the converter global control block
`ifndef ADCSQ_DEFINES_SVH
`define ADCSQ_DEFINES_SVH
// ==================================================
// global control register fields
`define ADCSQ_BIT_RUN 0
`define ADCSQ_BIT_RESET 1
`define ADCSQ_BIT_AZ 2
`define ADCSQ_BIT_CAL 3
`define ADCSQ_BIT_STBY 4
`define ADCSQ_BIT_DIAG 11
`define ADCSQ_CTRL_RESET 16'h0000
`define ADCSQ_CTRL_WMASK 16'hfff9
// ==================================================
// status register fields
`define ADCSQ_STAT_AZ_DONE 3
`define ADCSQ_STAT_CAL_DONE 4
`define ADCSQ_STAT_PTR_LSB 8
// ==================================================
// timing counts in clock cycles
`define ADCSQ_RESET_CYCLES 2
`define ADCSQ_AZ_CYCLES 76
`define ADCSQ_CAL_CYCLES 4944
`define ADCSQ_POR_CYCLES 4
`endif

// file: pkg/adcsq_pkg.sv
// types of the converter global control block
package adcsq_pkg;
   typedef enum logic [3:0] {
      ADCSQ_IDLE = 4'h1,
      ADCSQ_RUN = 4'h2,
      ADCSQ_AZ = 4'h4,
      ADCSQ_CAL = 4'h8
   } adcsq_state_t;
   typedef struct packed {
      logic [2:0] pos_sel;
      logic [2:0] neg_sel;
   } adcsq_sel_t;
   typedef struct packed {
      logic [7:0] pos_en;
      logic [7:0] neg_en;
      logic pos_vref;
      logic neg_vref;
      logic neg_gnd;
   } adcsq_route_t;
endpackage

// file: tb/adcsq_seq_model.sv
// behavioural instruction sequencer facing the global control block
`timescale 1ns/1ps
module adcsq_seq_model (
   // clock and reset
   input wire logic mclk,
   input wire logic reset,
   // control block side
   input wire logic seq_running,
   output logic instr_done,
   output adcsq_pkg::adcsq_sel_t instr_sel,
   // bench side: instruction length and select codes
   input wire logic [7:0] gap,
   input wire adcsq_pkg::adcsq_sel_t sel_in
);
   logic [7:0] cnt;
   assign instr_sel = sel_in;
   // ==================================================
   // instruction timer
   // cleared while stopped, so no completion pulse appears outside a run
   always_ff @(posedge mclk) begin
      if (reset || !seq_running) begin
         cnt <= 8'h00;
         instr_done <= 1'b0;
      end else begin
         instr_done <= (cnt == gap);
         cnt <= (cnt == gap) ? 8'h00 : cnt + 8'h01;
      end
   end
endmodule

// file: tb/tb.sv
// self-checking bench of the converter global control block
`timescale 1ns/1ps
module tb;
   logic mclk, reset, reg_wr, status_rd, instr_done, seq_running, fifo_clear, clock_gate;
   logic az_active, cal_active, fc_seen;
   logic [15:0] reg_wdata, global_control, status;
   logic [2:0] instr_ptr;
   logic [7:0] gap;
   adcsq_pkg::adcsq_sel_t sel, instr_sel;
   adcsq_pkg::adcsq_route_t route, route4;
   int miscompares, checks_done;
   // ==================================================
   // design and partner
   adcsq_control #(.CAL_CYCLES(20), .FOUR_CHAN(1'b0)) adcsq_control_inst (
      .mclk(mclk), .reset(reset), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
      .status_rd(status_rd), .global_control(global_control), .status(status),
      .instr_done(instr_done), .instr_sel(instr_sel), .seq_running(seq_running),
      .instr_ptr(instr_ptr), .fifo_clear(fifo_clear), .clock_gate(clock_gate),
      .az_active(az_active), .cal_active(cal_active), .route(route));
   // four-channel variant, watched only for its routing
   adcsq_control #(.CAL_CYCLES(20), .FOUR_CHAN(1'b1)) adcsq_control_inst_four (
      .mclk(mclk), .reset(reset), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
      .status_rd(status_rd), .global_control(), .status(), .instr_done(instr_done),
      .instr_sel(instr_sel), .seq_running(), .instr_ptr(), .fifo_clear(),
      .clock_gate(), .az_active(), .cal_active(), .route(route4));
   adcsq_seq_model adcsq_seq_model_inst (.mclk(mclk), .reset(reset),
      .seq_running(seq_running), .instr_done(instr_done), .instr_sel(instr_sel),
      .gap(gap), .sel_in(sel));
   // ==================================================
   // helpers
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   always @(posedge mclk) if (fifo_clear === 1'b1) fc_seen <= 1'b1;
   task automatic give_verdict();
      if (miscompares == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [19:0] got, input logic [19:0] exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge mclk);
   endtask
   task automatic wr(input logic [15:0] d);
      @(negedge mclk);
      reg_wr = 1'b1;
      reg_wdata = d;
      @(negedge mclk);
      reg_wr = 1'b0;
   endtask
   function automatic logic pick(input int idx);
      case (idx)
         0: return az_active;
         1: return cal_active;
         2: return seq_running;
         3: return instr_done;
         default: return global_control[1];
      endcase
   endfunction
   // a wait that runs out is reported and closes the run
   task automatic wait_sig(input int idx, input logic val, input int bound);
      int n;
      n = 0;
      while (pick(idx) !== val && n < bound) begin
         @(negedge mclk);
         n++;
      end
      chk(pick(idx), val);
      if (pick(idx) !== val) give_verdict();
   endtask
   function automatic adcsq_pkg::adcsq_route_t exp_route(input logic [2:0] c,
         input logic four, input logic diag);
      adcsq_pkg::adcsq_route_t r;
      r = '0;
      if (diag) begin
         if (c == 3'h1) begin
            r.pos_vref = 1'b1;
            r.neg_vref = 1'b1;
         end else if (c != 3'h0) begin
            r.pos_en[c] = 1'b1;
            r.neg_en[c] = 1'b1;
         end
      end else if (!four || c < 3'h4) begin
         r.pos_en[c] = 1'b1;
         if (c == 3'h0) r.neg_gnd = 1'b1;
         else r.neg_en[c] = 1'b1;
      end
      return r;
   endfunction
   // ==================================================
   // scenarios
   task automatic t_route(input logic diag);
      for (int c = 0; c < 8; c++) begin
         @(negedge mclk);
         sel = {c[2:0], c[2:0]};
         tick(2);
         chk(route, exp_route(c[2:0], 1'b0, diag));
         if (!diag) chk(route4, exp_route(c[2:0], 1'b1, 1'b0));
      end
   endtask
   task automatic t_corr_idle(input int b, input int idx, input int len, input int sb);
      int n;
      wr(16'h0001 << b);
      wait_sig(idx, 1'b1, 4);
      n = 0;
      while (pick(idx) === 1'b1 && n < 6000) begin
         @(negedge mclk);
         n++;
      end
      chk(19'(n), 19'(len));
      tick(3);
      chk({global_control[b], status[sb]}, 19'h1);
      @(negedge mclk);
      status_rd = 1'b1;
      @(negedge mclk);
      status_rd = 1'b0;
      tick(1);
      chk(status[sb], 1'b0);
   endtask
   task automatic t_run_stop();
      logic [2:0] p;
      wr(16'h0001);
      wait_sig(2, 1'b1, 4);
      wait_sig(3, 1'b1, 40);
      p = instr_ptr;
      wr(16'h0000);
      chk(instr_ptr, p + 3'h1);
      tick(2);
      chk(seq_running, 1'b1);
      wait_sig(2, 1'b0, 40);
      p = instr_ptr;
      tick(5);
      chk({global_control[0], seq_running, instr_ptr, status[10:8]}, {2'b00, p, p});
      wr(16'h0001);
      tick(2);
      chk({global_control[0], instr_ptr}, {1'b1, p});
   endtask
   // request made mid-instruction must wait for the boundary, then the run resumes
   task automatic t_corr_run(input int b, input int idx);
      wr(16'h0001);
      wait_sig(3, 1'b1, 40);
      wr(16'h0001 | (16'h0001 << b));
      tick(3);
      chk({pick(idx), seq_running}, 19'h1);
      wait_sig(idx, 1'b1, 40);
      wait_sig(idx, 1'b0, 200);
      wait_sig(2, 1'b1, 6);
   endtask
   task automatic t_reset_cmd();
      fc_seen = 1'b0;
      wr(16'h0002);
      tick(2);
      chk({seq_running, instr_ptr, status}, 19'h0);
      wait_sig(4, 1'b0, 6);
      chk(fc_seen, 1'b1);
   endtask
   task automatic t_standby();
      wr(16'h0010);
      tick(6);
      chk({clock_gate, global_control[1]}, 19'h3);
      wr(16'h0000);
      wait_sig(4, 1'b0, 8);
      chk({clock_gate, seq_running}, 19'h0);
   endtask
   // ==================================================
   // main sequence
   initial begin
      reset = 1'b1;
      reg_wr = 1'b0;
      reg_wdata = 16'h0000;
      status_rd = 1'b0;
      gap = 8'h0c;
      sel = '0;
      fc_seen = 1'b0;
      miscompares = 0;
      checks_done = 0;
      repeat (3) @(posedge mclk);
      @(negedge mclk);
      reset = 1'b0;
      wait_sig(4, 1'b1, 4);
      wait_sig(4, 1'b0, 20);
      chk({global_control[0], status}, 19'h0);
      t_route(1'b0);
      wr(16'h0800);
      t_route(1'b1);
      wr(16'h5240);
      tick(1);
      chk(global_control, 16'h5240);
      wr(16'h0000);
      t_corr_idle(2, 0, 76, 3);
      t_corr_idle(3, 1, 20, 4);
      t_run_stop();
      t_corr_run(2, 0);
      t_corr_run(3, 1);
      t_reset_cmd();
      t_standby();
      give_verdict();
   end
endmodule
